// [test/cp_filter_model.sv]
// call-progress filter model: integrates the pin over one measuring window
`timescale 1ns/1ps

module cp_filter_model
#(
   parameter int WIN = 1250
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // pin and measurement control
   input  wire logic        pin,
   input  wire logic        start,
   output logic [15:0]      ones,
   output logic             done
);
   logic [15:0] cnt_q;
   logic        busy_q;

   // count high cycles like an rc filter would; an unknown pin poisons the count on purpose
   always_ff @(posedge clk)
   begin
      done <= 1'b0;
      if (reset)
      begin
         busy_q <= 1'b0;
         cnt_q  <= '0;
         ones   <= '0;
      end
      else if (start)
      begin
         busy_q <= 1'b1;
         cnt_q  <= '0;
         ones   <= '0;
      end
      else if (busy_q)
      begin
         ones  <= ones + 16'(pin);
         cnt_q <= cnt_q + 16'h1;
         if (cnt_q == 16'(WIN - 1))
         begin
            busy_q <= 1'b0;
            done   <= 1'b1;
         end
      end
   end
endmodule // cp_filter_model

// [test/test_call_progress_pwm_control.sv]
// self-checking bench for the call-progress pwm control register
`timescale 1ns/1ps

module test_call_progress_pwm_control;
   import cp_pwm_pkg::*;
   logic        clk, reset, reg_wr_en, reg_rd_en, audio_valid, audio_ready, irq_pin_enable, irq_level;
   logic        soft_reset_pulse, pin, loop_en, meter_start, meter_done, pend, lp;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, e, d8;
   logic [15:0] tx_audio, rx_audio, meter_ones, tx, rx;
   logic [1:0]  code;
   int          n_fail, checked, seed, n, s, dx;
   logic [7:0]  rq[$];
   int          dq[$];

   call_progress_pwm_control u_call_progress_pwm_control (.clk(clk), .reset(reset),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .soft_reset_pulse(soft_reset_pulse), .audio_valid(audio_valid),
      .audio_ready(audio_ready), .tx_audio(tx_audio), .rx_audio(rx_audio),
      .irq_pin_enable(irq_pin_enable), .irq_level(irq_level), .call_progress_out_pin(pin),
      .barrier_loopback_enable(loop_en));
   cp_filter_model u_cp_filter_model (.clk(clk), .reset(reset), .pin(pin), .start(meter_start),
      .ones(meter_ones), .done(meter_done));

   ////////////////////////////////////////////////////////////////////////////////
   // clock, 50 ns period
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic results;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // bus and stream tasks, all entered and left 1 ns after a rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      reg_wr_en = 1'b1;
      reg_addr  = a;
      reg_wdata = dat;
      tick;
      reg_wr_en = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      rq.push_back(x);
      reg_rd_en = 1'b1;
      reg_addr  = a;
      tick;
      reg_rd_en = 1'b0;
   endtask

   // data only changes right after an edge that took it, so no offered sample is altered
   task automatic set_audio(input logic [15:0] t, input logic [15:0] r);
      n = 0;
      while (audio_ready !== 1'b1 && n < 3000)
      begin
         tick;
         n++;
      end
      // a source that is never accepted counts as a failure, not a silent hang
      if (n >= 3000)
      begin
         chk(1'b0, "audio ready timeout");
         results;
      end
      tick;
      tx_audio = t;
      rx_audio = r;
   endtask

   task automatic measure(input int x);
      dq.push_back(x);
      meter_start = 1'b1;
      tick;
      meter_start = 1'b0;
      n = 0;
      while (meter_done !== 1'b1 && n < 2000)
      begin
         tick;
         n++;
      end
      if (n >= 2000)
      begin
         chk(1'b0, "meter timeout");
         results;
      end
      tick;
   endtask

   // expected high cycles in 1250 cycles; trailing-edge style is high after the rising point
   function automatic int duty(input logic [1:0] c, input int sum);
      int lv;
      lv = (sum + 65536) * 1250 / 131072;
      if (c == 2'h2)
         return 1250 - lv;
      if (c == 2'h3)
         return 0;
      return lv;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // watcher: compares each result with the oldest note when it appears
   initial
   begin
      forever
      begin
         @(posedge clk);
         pend = reg_rd_en;
         #2;
         if (pend === 1'b1 && rq.size() > 0)
         begin
            e = rq.pop_front();
            chk(reg_rdata === e, "read data");
         end
         if (meter_done === 1'b1 && dq.size() > 0)
         begin
            dx = dq.pop_front();
            chk(int'(meter_ones) >= dx - (dx == 0 ? 0 : 40) && int'(meter_ones) <= dx + (dx == 0 ? 0 : 40)
               && ^meter_ones !== 1'bx, "pin duty");
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      seed = 32'h6f17;
      {reg_wr_en, reg_rd_en, reg_addr, reg_wdata, irq_pin_enable, irq_level, meter_start} = '0;
      {tx_audio, rx_audio, n_fail, checked} = '0;
      audio_valid = 1'b1;
      reset = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      reset = 1'b0;
      rd(CTRL1_OFFSET, CTRL1_RESET);
      chk(pin === 1'b0 && loop_en === 1'b0 && audio_ready === 1'b1, "outputs after reset");
      // valid stays high, so the second accepted sample fills the buffer before any drain
      tick;
      chk(audio_ready === 1'b0, "full buffer still ready");
      $display("test reset done");
      // random data, reserved bits set by noise
      for (int i = 0; i < 8; i++)
      begin
         d8 = 8'($random(seed)) & 8'h7F;
         wr(CTRL1_OFFSET, d8);
         rd(CTRL1_OFFSET, d8 & 8'h3A);
         chk(loop_en === d8[1], "loopback level");
      end
      wr(8'h02, 8'($random(seed)));
      rd(8'h02, 8'h00);
      // one idle edge so the read strobe is not lowered and raised in one time step
      tick;
      rd(CTRL1_OFFSET, d8 & 8'h3A);
      $display("test registers done");
      wr(CTRL1_OFFSET, 8'hBA);
      n = 0;
      while (soft_reset_pulse !== 1'b1 && n < 3)
      begin
         tick;
         n++;
      end
      chk(soft_reset_pulse === 1'b1, "soft reset pulse");
      tick;
      tick;
      rd(CTRL1_OFFSET, 8'h00);
      chk(loop_en === 1'b0, "loopback after soft reset");
      $display("test soft reset done");
      // every waveform code at two levels, then loopback replacing rx by tx
      for (int i = 0; i < 9; i++)
      begin
         code = (i < 8) ? 2'(i / 2) : 2'h1;
         tx   = (i < 8 && i % 2 == 1) ? 16'hD000 : 16'h3000;
         rx   = (i == 8) ? 16'hD000 : tx;
         lp   = (i == 8);
         s    = lp ? 2 * $signed(tx) : $signed(tx) + $signed(rx);
         // line side is taken as enabled and off-hook before loopback is set
         wr(CTRL1_OFFSET, {2'h0, code, 1'b1, 1'b0, lp, 1'b0});
         set_audio(tx, rx);
         repeat (2600) tick;
         measure(duty(code, s));
      end
      $display("test waveforms done");
      wr(CTRL1_OFFSET, 8'h10);
      repeat (100) tick;
      measure(0);
      $display("test disable done");
      wr(CTRL1_OFFSET, 8'h18);
      irq_pin_enable = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         irq_level = i[0];
         tick;
         tick;
         chk(pin === irq_level, "pin shared with interrupt");
      end
      $display("test interrupt pin done");
      n = 0;
      while ((rq.size() > 0 || dq.size() > 0) && n < 100)
      begin
         tick;
         n++;
      end
      if (n >= 100)
         chk(1'b0, "result notes left over");
      results;
   end
endmodule // test_call_progress_pwm_control

// [verilog/call_progress_pwm_control.sv]
// control register 1 with soft reset, call-progress pwm generators and barrier loopback
`timescale 1ns/1ps

module call_progress_pwm_control
   import cp_pwm_pkg::*;
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // register port
   input  wire logic               reg_wr_en,
   input  wire logic               reg_rd_en,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   output logic [7:0]              reg_rdata,
   output logic                    soft_reset_pulse,
   // audio stream
   input  wire logic               audio_valid,
   output logic                    audio_ready,
   input  wire logic [AUDIO_W-1:0] tx_audio,
   input  wire logic [AUDIO_W-1:0] rx_audio,
   // pin sharing with the interrupt logic
   input  wire logic               irq_pin_enable,
   input  wire logic               irq_level,
   // outputs
   output logic                    call_progress_out_pin,
   output logic                    barrier_loopback_enable
);

   ////////////////////////////////////////////////////////////////////////////
   // register decode and control state

   function automatic logic hit(input logic [7:0] addr);
      hit = (addr == CTRL1_OFFSET);
   endfunction

   logic       srst_q, srst_d;
   logic       rst_all;
   wave_type   wave_q, wave_d;
   logic       pwm_en_q, pwm_en_d;
   logic       loop_q, loop_d;
   logic [7:0] rdata_q, rdata_d;
   logic       wr_hit, rd_hit;

   assign wr_hit  = reg_wr_en && hit(reg_addr);
   assign rd_hit  = reg_rd_en && hit(reg_addr);
   // soft reset acts one cycle after the write, so the writing access completes first
   assign rst_all = reset || srst_q;

   // next control values
   always_comb
   begin
      wave_d   = wave_q;
      pwm_en_d = pwm_en_q;
      loop_d   = loop_q;
      srst_d   = wr_hit && reg_wdata[SOFT_RESET_BIT];
      if (wr_hit && !reg_wdata[SOFT_RESET_BIT])
      begin
         wave_d   = wave_type'(reg_wdata[WAVE_LSB +: 2]);
         pwm_en_d = reg_wdata[PWM_EN_BIT];
         loop_d   = reg_wdata[LOOP_BIT];
      end
      rdata_d = 8'h00;
      if (rd_hit)
      begin
         // soft reset bit and reserved bits read zero
         rdata_d[WAVE_LSB +: 2] = wave_q;
         rdata_d[PWM_EN_BIT]    = pwm_en_q;
         rdata_d[LOOP_BIT]      = loop_q;
      end
   end

   // all control state returns to reset value
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         wave_q   <= wave_type'(CTRL1_RESET[WAVE_LSB +: 2]);
         pwm_en_q <= CTRL1_RESET[PWM_EN_BIT];
         loop_q   <= CTRL1_RESET[LOOP_BIT];
         rdata_q  <= 8'h00;
      end
      else
      begin
         wave_q   <= wave_d;
         pwm_en_q <= pwm_en_d;
         loop_q   <= loop_d;
         rdata_q  <= rdata_d;
      end
   end

   // the request flop only lives one cycle
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         srst_q <= 1'b0;
      end
      else
      begin
         srst_q <= srst_d;
      end
   end

   assign reg_rdata               = rdata_q;
   assign soft_reset_pulse        = srst_q;
   assign barrier_loopback_enable = loop_q;

   ////////////////////////////////////////////////////////////////////////////
   // audio summing and buffering

   logic [AUDIO_W-1:0] rx_eff;
   logic [SUM_W-1:0]   sum_in, sum_out;
   logic               buf_valid, tick32;
   logic [SUM_W-1:0]   cur_q, cur_d;
   logic [SUM_W-1:0]   level;

   // looped data replaces the line-side receive path
   assign rx_eff = loop_q ? tx_audio : rx_audio;
   assign sum_in = SUM_W'($signed(tx_audio)) + SUM_W'($signed(rx_eff));

   // drains once per 32 kHz frame, so a slow frame rate back-pressures the source
   sample_buffer #(.WIDTH(SUM_W), .DEPTH(2)) u_buf
   (
      .clk       (clk),
      .reset     (rst_all),
      .in_valid  (audio_valid),
      .in_ready  (audio_ready),
      .in_data   (sum_in),
      .out_valid (buf_valid),
      .out_ready (tick32),
      .out_data  (sum_out)
   );

   // current sample, held when the buffer runs dry
   always_comb
   begin
      cur_d = (tick32 && buf_valid) ? sum_out : cur_q;
   end

   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         cur_q <= '0;
      end
      else
      begin
         cur_q <= cur_d;
      end
   end

   // offset binary: flipping the sign bit adds half scale
   assign level = {~cur_q[SUM_W-1], cur_q[SUM_W-2:0]};

   ////////////////////////////////////////////////////////////////////////////
   // frame counter and bit-rate enable

   localparam logic [10:0] P16    = 11'(PERIOD16);
   localparam logic [10:0] P32    = 11'(PERIOD32);
   localparam logic [14:0] PH_M   = 15'(PH_MOD);
   localparam logic [14:0] PH_S   = 15'(PH_STEP);

   logic [10:0] cnt_q, cnt_d, cnt32;
   logic [14:0] ph_q, ph_d;
   logic        bit_en;
   logic [15:0] ph_sum;

   assign ph_sum = {1'b0, ph_q} + {1'b0, PH_S};
   // fractional divider, 16.384 MHz average enable from 20 MHz
   assign bit_en = (ph_sum >= {1'b0, PH_M});

   always_comb
   begin
      cnt_d = (cnt_q == P16 - 11'h001) ? 11'h000 : cnt_q + 11'h001;
      ph_d  = bit_en ? 15'(ph_sum - {1'b0, PH_M}) : ph_sum[14:0];
   end

   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         cnt_q <= 11'h000;
         ph_q  <= 15'h0000;
      end
      else
      begin
         cnt_q <= cnt_d;
         ph_q  <= ph_d;
      end
   end

   assign tick32 = (cnt_q == 11'h000) || (cnt_q == P32);
   assign cnt32  = (cnt_q >= P32) ? cnt_q - P32 : cnt_q;

   ////////////////////////////////////////////////////////////////////////////
   // waveform generators

   logic [27:0]      prod16, prod32;
   logic [10:0]      width16, half16, rise32;
   logic             ds_q, ds_d;
   logic [SUM_W-1:0] acc_q, acc_d;
   logic [SUM_W:0]   acc_sum;
   logic             wave_bit;

   assign prod16  = 28'(level) * 28'(P16);
   assign prod32  = 28'(level) * 28'(P32);
   assign width16 = prod16[27:17];
   assign half16  = {1'b0, width16[10:1]};
   assign rise32  = prod32[27:17];
   assign acc_sum = {1'b0, acc_q} + {1'b0, level};

   // first-order modulator, carry is the output bit
   always_comb
   begin
      acc_d = acc_q;
      ds_d  = ds_q;
      if (bit_en)
      begin
         acc_d = acc_sum[SUM_W-1:0];
         ds_d  = acc_sum[SUM_W];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         acc_q <= '0;
         ds_q  <= 1'b0;
      end
      else
      begin
         acc_q <= acc_d;
         ds_q  <= ds_d;
      end
   end

   // waveform style selection
   always_comb
   begin
      case (wave_q)
         WAVE_DELTA_SIGMA: wave_bit = ds_q;
         // high portion straddles the 16 kHz sample point
         WAVE_BALANCED16:  wave_bit = (cnt_q < half16) || (cnt_q >= P16 - half16);
         // low at each 32 kHz boundary, rises at amplitude point
         WAVE_TRAILING32:  wave_bit = (cnt32 != 11'h000) && (cnt32 >= rise32);
         // reserved code gives a quiet pin
         default:          wave_bit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin output

   logic pin_q, pin_d;

   always_comb
   begin
      // interrupt use of the pin overrides the audio
      if (irq_pin_enable)
      begin
         pin_d = irq_level;
      end
      // pwm data when enabled, low otherwise
      else
      begin
         pin_d = pwm_en_q && wave_bit;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         pin_q <= 1'b0;
      end
      else
      begin
         pin_q <= pin_d;
      end
   end

   assign call_progress_out_pin = pin_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_reset_write;
      wr_hit && reg_wdata[SOFT_RESET_BIT];
   endsequence

   sequence s_plain_write;
      wr_hit && !reg_wdata[SOFT_RESET_BIT];
   endsequence

   property p_soft_reset;
      @(posedge clk) disable iff (reset)
      s_reset_write |=> soft_reset_pulse ##1 (!pwm_en_q && !loop_q && wave_q == WAVE_DELTA_SIGMA);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear control");

   property p_self_clear;
      @(posedge clk) disable iff (reset)
      soft_reset_pulse |=> !soft_reset_pulse;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("soft reset bit stuck");

   property p_read_zero;
      @(posedge clk) disable iff (reset)
      rd_hit |=> (reg_rdata[7] == 1'b0 && reg_rdata[6] == 1'b0 && reg_rdata[2] == 1'b0 && reg_rdata[0] == 1'b0);
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("reserved or reset bit read nonzero");

   property p_field_store;
      @(posedge clk) disable iff (rst_all)
      s_plain_write |=> (wave_q == $past(reg_wdata[5:4]) && loop_q == $past(reg_wdata[1])
                         && pwm_en_q == $past(reg_wdata[3]));
   endproperty
   a_field_store: assert property (p_field_store) else $error("control field not stored");

   property p_reserved_quiet;
      @(posedge clk) disable iff (reset)
      (wave_q == WAVE_RESERVED) |-> !wave_bit;
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code drives waveform");

   property p_ds_hold;
      @(posedge clk) disable iff (rst_all)
      !bit_en |=> $stable(ds_q);
   endproperty
   a_ds_hold: assert property (p_ds_hold) else $error("delta-sigma bit changed off enable");

   property p_balanced_centre;
      @(posedge clk) disable iff (reset)
      (wave_q == WAVE_BALANCED16 && width16 >= 11'h002 && cnt_q == 11'h000) |-> wave_bit;
   endproperty
   a_balanced_centre: assert property (p_balanced_centre) else $error("balanced pulse not centred");

   property p_trailing_fall;
      @(posedge clk) disable iff (reset)
      (wave_q == WAVE_TRAILING32 && tick32) |-> !wave_bit;
   endproperty
   a_trailing_fall: assert property (p_trailing_fall) else $error("output high at 32 kHz boundary");

   property p_pin_follows;
      @(posedge clk) disable iff (rst_all)
      (!irq_pin_enable && pwm_en_q) |=> (call_progress_out_pin == $past(wave_bit));
   endproperty
   a_pin_follows: assert property (p_pin_follows) else $error("pin does not carry pwm");

   property p_pin_off;
      @(posedge clk) disable iff (rst_all)
      (!irq_pin_enable && !pwm_en_q) |=> !call_progress_out_pin;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pwm on pin while disabled");

   property p_loopback;
      @(posedge clk) disable iff (reset)
      loop_q |-> (rx_eff == tx_audio && barrier_loopback_enable);
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback path not selected");

   property p_irq_pin;
      @(posedge clk) disable iff (rst_all)
      irq_pin_enable |=> (call_progress_out_pin == $past(irq_level));
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("pin not serving interrupt");

endmodule // call_progress_pwm_control

// [verilog/cp_pwm_pkg.sv]
// constants for the call-progress pwm control register and its generators
package cp_pwm_pkg;

   // clock and derived rates
   localparam int CLK_HZ      = 20_000_000;
   localparam int BIT_HZ      = 16_384_000;
   localparam int FRAME16_HZ  = 16_000;
   localparam int FRAME32_HZ  = 32_000;
   localparam int PERIOD16    = CLK_HZ / FRAME16_HZ;
   localparam int PERIOD32    = CLK_HZ / FRAME32_HZ;
   localparam int PH_MOD      = CLK_HZ / 1000;
   localparam int PH_STEP     = BIT_HZ / 1000;

   // register map
   localparam logic [7:0] CTRL1_OFFSET  = 8'h01;
   localparam logic [7:0] CTRL1_RESET   = 8'h00;
   localparam int         SOFT_RESET_BIT = 7;
   localparam int         WAVE_LSB       = 4;
   localparam int         PWM_EN_BIT     = 3;
   localparam int         LOOP_BIT       = 1;

   // waveform codes
   typedef enum logic [1:0]
   {
      WAVE_DELTA_SIGMA = 2'h0,
      WAVE_BALANCED16  = 2'h1,
      WAVE_TRAILING32  = 2'h2,
      WAVE_RESERVED    = 2'h3
   } wave_type;

   // audio sample widths
   localparam int AUDIO_W = 16;
   localparam int SUM_W   = AUDIO_W + 1;

endpackage

// [verilog/sample_buffer.sv]
// two-entry valid/ready buffer for summed audio samples
`timescale 1ns/1ps

module sample_buffer
   import cp_pwm_pkg::*;
#(
   parameter int WIDTH = SUM_W,
   parameter int DEPTH = 2
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [PW:0]      cnt_q, cnt_d;
   logic             push, pop;

   // honest full and empty flags
   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // next pointers, count and storage
   always_comb
   begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      if (push)
      begin
         mem_d[wr_q] = in_data;
         wr_d = (wr_q == PW'(DEPTH-1)) ? '0 : PW'(wr_q + 1'b1);
      end
      if (pop)
      begin
         rd_d = (rd_q == PW'(DEPTH-1)) ? '0 : PW'(rd_q + 1'b1);
      end
      cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
   end

   // register stage
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= '0;
         end
      end
      else
      begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
         mem_q <= mem_d;
      end
   end

endmodule // sample_buffer
